// file: rtl/b1sfr_map.sv
// Bank-one special function register map behind an AXI4-Lite slave.
// Assumes the core reaches it only over the bus, plus the status and event pins below.
//
// Behaviour
// [R1] Unimplemented locations and bits in this bank read back as zero.
// [R2] Mirrored core registers decode at the same low offset in every bank.
// [R3] The high-byte latch holds five bits copied into counter bits 12:8 on a load.
// [R4] The counter's upper byte has no data-memory address of its own.
// [R5] Port A direction bit 5 ignores writes and always reads one.
// [R6] The indirect location accesses the address held in the pointer register, with the bank-high select flag bit 7 as address bit 8.
// [R7] Writes to unimplemented addresses or bits change no implemented register.
`timescale 1ns/1ps
module b1sfr_map (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [b1sfr_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [b1sfr_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [b1sfr_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [b1sfr_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic                                pc_advance,
  input  wire logic [2:0]                          int_flag_set,
  input  wire logic                                osc_stable,
  input  wire logic [5:0]                          serial_status,
  output logic [12:0]                              program_counter,
  output logic [7:0]                               option_bits,
  output logic [7:0]                               core_flags,
  output logic [7:0]                               port_a_direction,
  output logic [7:0]                               port_b_direction,
  output logic [7:0]                               interrupt_control,
  output logic [7:0]                               timer2_period
);

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  options;
    logic [7:0]  flags;
    logic [7:0]  pointer;
    logic [7:0]  port_a_dir;
    logic [7:0]  port_b_dir;
    logic [4:0]  pc_latch;
    logic [7:0]  int_ctrl;
    logic [7:0]  irq_en_1;
    logic [7:0]  irq_en_2;
    logic [7:0]  pwr_flags;
    logic [7:0]  osc_ctrl;
    logic [7:0]  osc_trim;
    logic [7:0]  t2_period;
    logic [7:0]  ssp_addr;
    logic [7:0]  ssp_state;
    logic [7:0]  adc_low;
    logic [7:0]  adc_ctrl;
    logic        osc_meta;
    logic        osc_sync;
    logic [5:0]  ssp_meta;
    logic [5:0]  ssp_sync;
  } b1sfr_state_t;

  b1sfr_state_t                    q_reg;
  b1sfr_state_t                    q_next;
  logic                            wr_req;
  logic [b1sfr_pkg::WORD_W-1:0]    wr_word;
  logic [7:0]                      wr_data;
  logic [b1sfr_pkg::WORD_W-1:0]    rd_word;
  logic [7:0]                      rd_data;
  b1sfr_pkg::b1sfr_sel_t           rd_sel;
  b1sfr_pkg::b1sfr_sel_t           wr_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end
  b1sfr_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_req        (wr_req),
    .wr_word       (wr_word),
    .wr_data       (wr_data),
    .rd_word       (rd_word),
    .rd_data       (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic b1sfr_pkg::b1sfr_sel_t sel_of(input logic [8:0] addr);
    logic [6:0] low;
    low    = addr[6:0];
    sel_of = b1sfr_pkg::SEL_NONE;
    // Mirrored core registers ignore the bank bits, see [R2]
    if (low == b1sfr_pkg::IDX_INDIRECT_ACCESS_PORT[6:0])
      sel_of = b1sfr_pkg::SEL_INDIRECT;
    else if (low == b1sfr_pkg::IDX_PROGRAM_COUNTER_LOW[6:0])
      sel_of = b1sfr_pkg::SEL_PC_LOW;
    else if (low == b1sfr_pkg::IDX_CORE_FLAGS_BANK_SELECT[6:0])
      sel_of = b1sfr_pkg::SEL_FLAGS;
    else if (low == b1sfr_pkg::IDX_INDIRECT_POINTER[6:0])
      sel_of = b1sfr_pkg::SEL_POINTER;
    else if (low == b1sfr_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH[6:0])
      sel_of = b1sfr_pkg::SEL_PC_LATCH;
    else if (low == b1sfr_pkg::IDX_INTERRUPT_CONTROL[6:0])
      sel_of = b1sfr_pkg::SEL_INT_CTRL;
    else if (addr[8:7] == b1sfr_pkg::BANK_ONE)
    begin
      // Other banks' own registers live elsewhere; here they decode to nothing
      if (addr == b1sfr_pkg::IDX_TIMER_AND_PULLUP_OPTIONS)
        sel_of = b1sfr_pkg::SEL_OPTIONS;
      else if (addr == b1sfr_pkg::IDX_PORT_A_DIRECTION)
        sel_of = b1sfr_pkg::SEL_PORT_A_DIR;
      else if (addr == b1sfr_pkg::IDX_PORT_B_DIRECTION)
        sel_of = b1sfr_pkg::SEL_PORT_B_DIR;
      else if (addr == b1sfr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_1)
        sel_of = b1sfr_pkg::SEL_IRQ_EN_1;
      else if (addr == b1sfr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_2)
        sel_of = b1sfr_pkg::SEL_IRQ_EN_2;
      else if (addr == b1sfr_pkg::IDX_POWER_RESET_FLAGS)
        sel_of = b1sfr_pkg::SEL_PWR_FLAGS;
      else if (addr == b1sfr_pkg::IDX_OSCILLATOR_CONTROL)
        sel_of = b1sfr_pkg::SEL_OSC_CTRL;
      else if (addr == b1sfr_pkg::IDX_OSCILLATOR_TRIM)
        sel_of = b1sfr_pkg::SEL_OSC_TRIM;
      else if (addr == b1sfr_pkg::IDX_TIMER2_PERIOD)
        sel_of = b1sfr_pkg::SEL_T2_PERIOD;
      else if (addr == b1sfr_pkg::IDX_SERIAL_PORT_SLAVE_ADDRESS)
        sel_of = b1sfr_pkg::SEL_SSP_ADDR;
      else if (addr == b1sfr_pkg::IDX_SERIAL_PORT_STATE_FLAGS)
        sel_of = b1sfr_pkg::SEL_SSP_STATE;
      else if (addr == b1sfr_pkg::IDX_ADC_RESULT_LOW)
        sel_of = b1sfr_pkg::SEL_ADC_LOW;
      else if (addr == b1sfr_pkg::IDX_ADC_CONTROL_SECOND)
        sel_of = b1sfr_pkg::SEL_ADC_CTRL;
    end
  endfunction

  // Indirect access re-decodes the pointer; pointing back at itself hits nothing
  function automatic b1sfr_pkg::b1sfr_sel_t resolve(input logic [b1sfr_pkg::WORD_W-1:0] word,
                                                    input logic [7:0] flags,
                                                    input logic [7:0] pointer);
    b1sfr_pkg::b1sfr_sel_t s;
    s = b1sfr_pkg::SEL_NONE;
    // Words past the data-memory space stay unmapped
    if (!word[b1sfr_pkg::WORD_W-1])
      s = sel_of(word[8:0]);
    if (s == b1sfr_pkg::SEL_INDIRECT)
    begin
      s = sel_of({flags[b1sfr_pkg::POS_BANK_HIGH_SELECT], pointer});  // see [R6]
      if (s == b1sfr_pkg::SEL_INDIRECT)
        s = b1sfr_pkg::SEL_NONE;
    end
    resolve = s;
  endfunction

  assign rd_sel = resolve(rd_word, q_reg.flags, q_reg.pointer);
  assign wr_sel = resolve(wr_word, q_reg.flags, q_reg.pointer);

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    rd_data = 8'h00;  // see [R1]
    unique case (rd_sel)
      b1sfr_pkg::SEL_NONE:       rd_data = 8'h00;  // see [R1]
      b1sfr_pkg::SEL_INDIRECT:   rd_data = 8'h00;
      b1sfr_pkg::SEL_OPTIONS:    rd_data = q_reg.options;
      b1sfr_pkg::SEL_PC_LOW:     rd_data = q_reg.pc[7:0];
      b1sfr_pkg::SEL_FLAGS:      rd_data = q_reg.flags;
      b1sfr_pkg::SEL_POINTER:    rd_data = q_reg.pointer;
      b1sfr_pkg::SEL_PORT_A_DIR: rd_data = q_reg.port_a_dir;
      b1sfr_pkg::SEL_PORT_B_DIR: rd_data = q_reg.port_b_dir;
      b1sfr_pkg::SEL_PC_LATCH:   rd_data = {3'h0, q_reg.pc_latch};  // see [R1]
      b1sfr_pkg::SEL_INT_CTRL:   rd_data = q_reg.int_ctrl;
      b1sfr_pkg::SEL_IRQ_EN_1:   rd_data = q_reg.irq_en_1;
      b1sfr_pkg::SEL_IRQ_EN_2:   rd_data = q_reg.irq_en_2;
      b1sfr_pkg::SEL_PWR_FLAGS:  rd_data = q_reg.pwr_flags;
      b1sfr_pkg::SEL_OSC_CTRL:
        rd_data = q_reg.osc_ctrl
                | (8'(q_reg.osc_sync) << b1sfr_pkg::POS_OSC_STABLE);
      b1sfr_pkg::SEL_OSC_TRIM:   rd_data = q_reg.osc_trim;
      b1sfr_pkg::SEL_T2_PERIOD:  rd_data = q_reg.t2_period;
      b1sfr_pkg::SEL_SSP_ADDR:   rd_data = q_reg.ssp_addr;
      b1sfr_pkg::SEL_SSP_STATE:  rd_data = q_reg.ssp_state | {2'h0, q_reg.ssp_sync};
      b1sfr_pkg::SEL_ADC_LOW:    rd_data = q_reg.adc_low;
      b1sfr_pkg::SEL_ADC_CTRL:   rd_data = q_reg.adc_ctrl;
      default:                   rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register updates
  always_comb
  begin
    q_next          = q_reg;
    // Status pins come from other clock domains
    q_next.osc_meta = osc_stable;
    q_next.osc_sync = q_reg.osc_meta;
    q_next.ssp_meta = serial_status;
    q_next.ssp_sync = q_reg.ssp_meta;
    if (pc_advance)
    begin
      q_next.pc = q_reg.pc + 13'h0001;
    end
    if (wr_req)
    begin
      unique case (wr_sel)
        b1sfr_pkg::SEL_OPTIONS:    q_next.options = wr_data;
        // A load takes the latch into the upper bits; no path writes them alone
        b1sfr_pkg::SEL_PC_LOW:     q_next.pc = {q_reg.pc_latch, wr_data};  // see [R3] [R4]
        b1sfr_pkg::SEL_FLAGS:
          q_next.flags = (q_reg.flags & ~b1sfr_pkg::MSK_FLAGS)
                       | (wr_data & b1sfr_pkg::MSK_FLAGS);  // see [R7]
        b1sfr_pkg::SEL_POINTER:    q_next.pointer = wr_data;
        b1sfr_pkg::SEL_PORT_A_DIR:
        begin
          q_next.port_a_dir = wr_data;
          q_next.port_a_dir[b1sfr_pkg::POS_PORT_A_PIN5_DIR] = 1'b1;  // see [R5]
        end
        b1sfr_pkg::SEL_PORT_B_DIR: q_next.port_b_dir = wr_data;
        b1sfr_pkg::SEL_PC_LATCH:   q_next.pc_latch = wr_data[4:0];  // see [R3]
        b1sfr_pkg::SEL_INT_CTRL:   q_next.int_ctrl = wr_data;
        b1sfr_pkg::SEL_IRQ_EN_1:   q_next.irq_en_1 = wr_data & b1sfr_pkg::MSK_IRQ_EN_1;
        b1sfr_pkg::SEL_IRQ_EN_2:   q_next.irq_en_2 = wr_data & b1sfr_pkg::MSK_IRQ_EN_2;
        b1sfr_pkg::SEL_PWR_FLAGS:  q_next.pwr_flags = wr_data & b1sfr_pkg::MSK_PWR_FLAGS;
        b1sfr_pkg::SEL_OSC_CTRL:   q_next.osc_ctrl = wr_data & b1sfr_pkg::MSK_OSC_CTRL;
        b1sfr_pkg::SEL_OSC_TRIM:   q_next.osc_trim = wr_data & b1sfr_pkg::MSK_OSC_TRIM;
        b1sfr_pkg::SEL_T2_PERIOD:  q_next.t2_period = wr_data;
        b1sfr_pkg::SEL_SSP_ADDR:   q_next.ssp_addr = wr_data;
        b1sfr_pkg::SEL_SSP_STATE:  q_next.ssp_state = wr_data & b1sfr_pkg::MSK_SSP_STATE;
        b1sfr_pkg::SEL_ADC_LOW:    q_next.adc_low = wr_data;
        b1sfr_pkg::SEL_ADC_CTRL:   q_next.adc_ctrl = wr_data & b1sfr_pkg::MSK_ADC_CTRL;
        default:                   q_next.pc = q_next.pc;  // see [R7]
      endcase
    end
    // Hardware events win over a clearing write in the same cycle
    q_next.int_ctrl[2:0] = q_next.int_ctrl[2:0] | int_flag_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg            <= '0;
      q_reg.pc         <= {b1sfr_pkg::RST_PC_LATCH, b1sfr_pkg::RST_PC_LOW};
      q_reg.options    <= b1sfr_pkg::RST_OPTIONS;
      q_reg.flags      <= b1sfr_pkg::RST_FLAGS;
      q_reg.pointer    <= b1sfr_pkg::RST_POINTER;
      q_reg.port_a_dir <= b1sfr_pkg::RST_PORT_A_DIR;
      q_reg.port_b_dir <= b1sfr_pkg::RST_PORT_B_DIR;
      q_reg.pc_latch   <= b1sfr_pkg::RST_PC_LATCH;
      q_reg.int_ctrl   <= b1sfr_pkg::RST_INT_CTRL;
      q_reg.irq_en_1   <= b1sfr_pkg::RST_IRQ_EN_1;
      q_reg.irq_en_2   <= b1sfr_pkg::RST_IRQ_EN_2;
      q_reg.pwr_flags  <= b1sfr_pkg::RST_PWR_FLAGS;
      q_reg.osc_ctrl   <= b1sfr_pkg::RST_OSC_CTRL;
      q_reg.osc_trim   <= b1sfr_pkg::RST_OSC_TRIM;
      q_reg.t2_period  <= b1sfr_pkg::RST_T2_PERIOD;
      q_reg.ssp_addr   <= b1sfr_pkg::RST_SSP_ADDR;
      q_reg.ssp_state  <= b1sfr_pkg::RST_SSP_STATE;
      q_reg.adc_low    <= b1sfr_pkg::RST_ADC_LOW;
      q_reg.adc_ctrl   <= b1sfr_pkg::RST_ADC_CTRL;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign program_counter   = q_reg.pc;
  assign option_bits       = q_reg.options;
  assign core_flags        = q_reg.flags;
  assign port_a_direction  = q_reg.port_a_dir;
  assign port_b_direction  = q_reg.port_b_dir;
  assign interrupt_control = q_reg.int_ctrl;
  assign timer2_period     = q_reg.t2_period;

endmodule

// file: rtl/b1sfr_pkg.sv
// Constants, register indices, reset values and write masks of the bank-one register map.
// Assumes the bus front end maps register index n to AXI byte address 4*n.
package b1sfr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned  AXI_ADDR_W = 12;
  localparam int unsigned  AXI_DATA_W = 32;
  localparam int unsigned  WORD_W     = 10;
  localparam logic [1:0]   RESP_OKAY  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices, as data-memory addresses
  localparam logic [8:0] IDX_INDIRECT_ACCESS_PORT      = 9'h080;
  localparam logic [8:0] IDX_TIMER_AND_PULLUP_OPTIONS  = 9'h081;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_LOW       = 9'h082;
  localparam logic [8:0] IDX_CORE_FLAGS_BANK_SELECT    = 9'h083;
  localparam logic [8:0] IDX_INDIRECT_POINTER          = 9'h084;
  localparam logic [8:0] IDX_PORT_A_DIRECTION          = 9'h085;
  localparam logic [8:0] IDX_PORT_B_DIRECTION          = 9'h086;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 9'h08a;
  localparam logic [8:0] IDX_INTERRUPT_CONTROL         = 9'h08b;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_1   = 9'h08c;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_2   = 9'h08d;
  localparam logic [8:0] IDX_POWER_RESET_FLAGS         = 9'h08e;
  localparam logic [8:0] IDX_OSCILLATOR_CONTROL        = 9'h08f;
  localparam logic [8:0] IDX_OSCILLATOR_TRIM          = 9'h090;
  localparam logic [8:0] IDX_TIMER2_PERIOD             = 9'h092;
  localparam logic [8:0] IDX_SERIAL_PORT_SLAVE_ADDRESS = 9'h093;
  localparam logic [8:0] IDX_SERIAL_PORT_STATE_FLAGS   = 9'h094;
  localparam logic [8:0] IDX_ADC_RESULT_LOW            = 9'h09e;
  localparam logic [8:0] IDX_ADC_CONTROL_SECOND        = 9'h09f;
  localparam logic [1:0] BANK_ONE                      = 2'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_OPTIONS    = 8'hff;
  localparam logic [7:0] RST_PC_LOW     = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h18;
  localparam logic [7:0] RST_POINTER    = 8'h00;
  localparam logic [7:0] RST_PORT_A_DIR = 8'hff;
  localparam logic [7:0] RST_PORT_B_DIR = 8'hff;
  localparam logic [4:0] RST_PC_LATCH   = 5'h00;
  localparam logic [7:0] RST_INT_CTRL   = 8'h00;
  localparam logic [7:0] RST_IRQ_EN_1   = 8'h00;
  localparam logic [7:0] RST_IRQ_EN_2   = 8'h00;
  localparam logic [7:0] RST_PWR_FLAGS  = 8'h00;
  localparam logic [7:0] RST_OSC_CTRL   = 8'h00;
  localparam logic [7:0] RST_OSC_TRIM   = 8'h00;
  localparam logic [7:0] RST_T2_PERIOD  = 8'hff;
  localparam logic [7:0] RST_SSP_ADDR   = 8'h00;
  localparam logic [7:0] RST_SSP_STATE  = 8'h00;
  localparam logic [7:0] RST_ADC_LOW    = 8'h00;
  localparam logic [7:0] RST_ADC_CTRL   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Implemented, software-writable bits
  localparam logic [7:0] MSK_FLAGS     = 8'he7;
  localparam logic [7:0] MSK_IRQ_EN_1  = 8'h4f;
  localparam logic [7:0] MSK_IRQ_EN_2  = 8'h10;
  localparam logic [7:0] MSK_PWR_FLAGS = 8'h03;
  localparam logic [7:0] MSK_OSC_CTRL  = 8'h70;
  localparam logic [7:0] MSK_OSC_TRIM  = 8'h3f;
  localparam logic [7:0] MSK_SSP_STATE = 8'hc0;
  localparam logic [7:0] MSK_ADC_CTRL  = 8'hcf;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned POS_BANK_HIGH_SELECT  = 7;
  localparam int unsigned POS_PORT_A_PIN5_DIR   = 5;
  localparam int unsigned POS_OSC_STABLE        = 2;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_INDIRECT, SEL_OPTIONS, SEL_PC_LOW, SEL_FLAGS, SEL_POINTER,
    SEL_PORT_A_DIR, SEL_PORT_B_DIR, SEL_PC_LATCH, SEL_INT_CTRL, SEL_IRQ_EN_1,
    SEL_IRQ_EN_2, SEL_PWR_FLAGS, SEL_OSC_CTRL, SEL_OSC_TRIM, SEL_T2_PERIOD,
    SEL_SSP_ADDR, SEL_SSP_STATE, SEL_ADC_LOW, SEL_ADC_CTRL
  } b1sfr_sel_t;

endpackage

// file: rtl/b1sfr_axil_slave.sv
// AXI4-Lite slave front end: turns bus traffic into one-cycle register accesses.
// Assumes the register logic answers a read combinationally from the word index.
`timescale 1ns/1ps
module b1sfr_axil_slave (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [b1sfr_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [b1sfr_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [b1sfr_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [b1sfr_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic                                     wr_req,
  output logic [b1sfr_pkg::WORD_W-1:0]             wr_word,
  output logic [7:0]                               wr_data,
  output logic [b1sfr_pkg::WORD_W-1:0]             rd_word,
  input  wire logic [7:0]                          rd_data
);

  typedef struct packed {
    logic                            aw_held;
    logic                            w_held;
    logic                            w_lane0;
    logic [b1sfr_pkg::WORD_W-1:0]    wword;
    logic [7:0]                      wdata;
    logic                            bvalid;
    logic                            rd_pend;
    logic [b1sfr_pkg::WORD_W-1:0]    rword;
    logic [7:0]                      rdata;
    logic                            rvalid;
  } b1sfr_axi_state_t;

  b1sfr_axi_state_t q_reg;
  b1sfr_axi_state_t q_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign s_axi_awready = !q_reg.aw_held && !q_reg.bvalid;
  assign s_axi_wready  = !q_reg.w_held && !q_reg.bvalid;
  assign s_axi_arready = !q_reg.rd_pend && !q_reg.rvalid;
  // Only byte lane 0 carries register data
  assign wr_req        = q_reg.aw_held && q_reg.w_held && !q_reg.bvalid && q_reg.w_lane0;
  assign wr_word       = q_reg.wword;
  assign wr_data       = q_reg.wdata;
  assign rd_word       = q_reg.rword;
  assign s_axi_bvalid  = q_reg.bvalid;
  assign s_axi_bresp   = b1sfr_pkg::RESP_OKAY;
  assign s_axi_rvalid  = q_reg.rvalid;
  assign s_axi_rresp   = b1sfr_pkg::RESP_OKAY;
  assign s_axi_rdata   = {24'h000000, q_reg.rdata};

  always_comb
  begin
    q_next = q_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      q_next.aw_held = 1'b1;
      q_next.wword   = s_axi_awaddr[b1sfr_pkg::AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      q_next.w_held  = 1'b1;
      q_next.w_lane0 = s_axi_wstrb[0];
      q_next.wdata   = s_axi_wdata[7:0];
    end
    if (q_reg.aw_held && q_reg.w_held && !q_reg.bvalid)
    begin
      q_next.aw_held = 1'b0;
      q_next.w_held  = 1'b0;
      q_next.bvalid  = 1'b1;
    end
    if (q_reg.bvalid && s_axi_bready)
    begin
      q_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      q_next.rd_pend = 1'b1;
      q_next.rword   = s_axi_araddr[b1sfr_pkg::AXI_ADDR_W-1:2];
    end
    if (q_reg.rd_pend)
    begin
      q_next.rd_pend = 1'b0;
      q_next.rdata   = rd_data;
      q_next.rvalid  = 1'b1;
    end
    if (q_reg.rvalid && s_axi_rready)
    begin
      q_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

endmodule

// file: test/b1sfr_map_props.sv
// Checks on the bank-one register map, bound to its top module.
// Assumes one clock, aclk, and a synchronous active-low reset.
`timescale 1ns/1ps
module b1sfr_map_props (
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, pc_advance,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [12:0] program_counter,
  input wire logic [7:0]  core_flags, port_a_direction
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_dir5; port_a_direction[5]; endproperty
  a_dir5: assert property (p_dir5) else $error("dir bit 5 low");
  property p_ro; core_flags[4:3] == 2'h3; endproperty
  a_ro: assert property (p_ro) else $error("flags 4:3 moved");
  property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rhi: assert property (p_rhi) else $error("rdata upper set");
  property p_rlat; s_ar |=> !s_axi_arready ##1 s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_wlat; s_wt |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
  a_wlat: assert property (p_wlat) else $error("write late");
  // Upper byte moves only by counting or by a low-byte load
  property p_hi; !$past(pc_advance) && !$rose(s_axi_bvalid) |->
    $stable(program_counter[12:8]); endproperty
  a_hi: assert property (p_hi) else $error("upper byte moved");
  property p_adv; pc_advance |=>
    $rose(s_axi_bvalid) || program_counter == $past(program_counter) + 13'h1; endproperty
  a_adv: assert property (p_adv) else $error("no count");
endmodule
bind b1sfr_map b1sfr_map_props u_b1sfr_map_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .pc_advance, .s_axi_bresp, .s_axi_rdata, .program_counter, .core_flags,
  .port_a_direction);

// file: test/b1sfr_core_model.sv
// Core model: issues one AXI4-Lite write or read at a time.
// Assumes its tasks are called from a process tied to aclk.
`timescale 1ns/1ps
module b1sfr_core_model (
  input wire logic        aclk, awready, wready, bvalid, arready, rvalid,
  input wire logic [31:0] rdata,
  output logic [11:0]     awaddr, araddr,
  output logic [31:0]     wdata,
  output logic [3:0]      wstrb,
  output logic            awvalid, wvalid, bready, arvalid, rready
);
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end
  ////////////////////////////////
  // Released addresses and write data invert so a stale value never looks valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
      if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask
endmodule

// file: test/tb_top.sv
// Bench for the bank-one register map: table of write/read rows, then edge cases.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [8:0] wa; logic [7:0] d; logic s; logic [8:0] ra; logic [7:0] e;}
    b1sfr_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0, pc_advance = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [12:0] prog_cnt;
  logic [7:0]  dir_a;
  int          mismatches = 0, num_checks = 0;
  // Strobe 0 rows read reset values and show a refused write
  b1sfr_row_t rows [11] = '{'{9'h081, 8'h00, 1'b0, 9'h081, 8'hff},
    '{9'h08f, 8'h70, 1'b0, 9'h08f, 8'h04}, '{9'h094, 8'hc0, 1'b0, 9'h094, 8'h15},
    '{9'h085, 8'h00, 1'b1, 9'h085, 8'h20}, '{9'h08c, 8'hff, 1'b1, 9'h08c, 8'h4f},
    '{9'h087, 8'hff, 1'b1, 9'h087, 8'h00}, '{9'h105, 8'hff, 1'b1, 9'h105, 8'h00},
    '{9'h184, 8'h9f, 1'b1, 9'h084, 8'h9f}, '{9'h000, 8'h41, 1'b1, 9'h09f, 8'h41},
    '{9'h08a, 8'hff, 1'b1, 9'h10a, 8'h1f}, '{9'h083, 8'h00, 1'b1, 9'h083, 8'h18}};
  always #5 aclk = ~aclk;
  b1sfr_core_model u_b1sfr_core_model (.aclk, .awready, .wready, .bvalid, .arready, .rvalid,
    .rdata, .awaddr, .araddr, .wdata, .wstrb, .awvalid, .wvalid, .bready, .arvalid, .rready);
  b1sfr_map u_b1sfr_map (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pc_advance(pc_advance), .int_flag_set(3'h0), .osc_stable(1'b1),
    .serial_status(6'h15), .program_counter(prog_cnt), .option_bits(), .core_flags(),
    .port_a_direction(dir_a), .port_b_direction(), .interrupt_control(), .timer2_period());
  ////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      u_b1sfr_core_model.wr({1'b0, rows[i].wa, 2'h0}, rows[i].d, {3'h0, rows[i].s});
      u_b1sfr_core_model.rd({1'b0, rows[i].ra, 2'h0}, rd_v);
      chk("row", rd_v, {24'h0, rows[i].e});
    end
    u_b1sfr_core_model.wr(12'h208, 8'h34, 4'h1);
    chk("counter", {19'h0, prog_cnt}, 32'h1f34);
    @(posedge aclk);
    pc_advance <= 1'b1;
    @(posedge aclk);
    pc_advance <= 1'b0;
    u_b1sfr_core_model.rd(12'h208, rd_v);
    chk("counter_low", rd_v, 32'h35);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("dir_a", {24'h0, dir_a}, 32'hff);
    finish_test();
  end
  initial
  begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule
